// *** bench/tmrev_evnet.sv ***
`timescale 1ns/1ns
`default_nettype none
module tmrev_evnet (
  input  wire logic         i_clk,
  input  wire logic [255:0] i_pub,
  output logic      [255:0] o_chan
);
  int         pub_cnt = 0;
  logic [7:0] pub_idx = 8'h00;
  initial o_chan = 256'h0;
  // Count publication pulses and remember the channel used
  always @(posedge i_clk) begin
    for (int c = 0; c < 256; c++) begin
      if (i_pub[c]) begin
        pub_cnt++;
        pub_idx = 8'(c);
      end
    end
  end
  task automatic fire(input logic [7:0] ch);
    o_chan <= 256'h1 << ch;
    @(posedge i_clk);
    #1;
    o_chan <= 256'h0;
  endtask
endmodule // tmrev_evnet
`default_nettype wire

// *** bench/tmrev_top_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module tmrev_top_properties (
  input wire logic         i_clk_sys,
  input wire logic         i_rst_b,
  input wire logic [11:0]  i_addr,
  input wire logic [31:0]  i_wdata,
  input wire logic         i_wr,
  input wire logic         i_rd,
  input wire logic [31:0]  o_rdata,
  input wire logic [255:0] o_evchan,
  input wire logic         o_irq,
  input wire logic         o_running,
  input wire logic [31:0]  o_counter
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  chk_stop_halts: assert property (
    i_wr && i_addr == tmrev_pkg::OFF_STOP && i_wdata[0] |=> !o_running)
    else $error("timer running after stop task");
  chk_clear_zero: assert property (
    i_wr && i_addr == tmrev_pkg::OFF_CLEAR && i_wdata[0] |=> o_counter == 32'h0)
    else $error("counter not zero after clear task");
  chk_irq_cleared: assert property (
    i_wr && i_addr == tmrev_pkg::OFF_INTCLR && i_wdata[5:0] == 6'h3F |=> !o_irq)
    else $error("irq high with all enables cleared");
  chk_set_readback: assert property (
    (i_wr && i_addr == tmrev_pkg::OFF_INTSET && i_wdata[0])
    ##1 (i_rd && i_addr == tmrev_pkg::OFF_INTCLR) |=> o_rdata[0])
    else $error("enable not seen after set");
  chk_sub_fields: assert property (
    i_rd && i_addr == tmrev_pkg::OFF_SUB_START |=> (o_rdata & ~tmrev_pkg::SUB_MASK) == 32'h0)
    else $error("subscription reserved bits set");
  chk_short_bits: assert property (
    i_rd && i_addr == tmrev_pkg::OFF_EVENT_TASK_SHORTCUTS |=> o_rdata[31:12] == 20'h0)
    else $error("shortcut reserved bits set");
  chk_pub_single: assert property (
    |o_evchan |=> (o_evchan & $past(o_evchan)) == 256'h0)
    else $error("publication pulse longer than one cycle");
  chk_unmapped_zero: assert property (
    i_rd && i_addr == 12'hFFC |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  cover property (o_irq);
  cover property (|o_evchan);
  cover property (i_wr && i_addr == tmrev_pkg::OFF_CLEAR ##1 o_counter == 32'h0);
endmodule // tmrev_top_properties
bind tmrev_top tmrev_top_properties i_tmrev_top_properties (.i_clk_sys(i_clk_sys),
  .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_evchan(o_evchan), .o_irq(o_irq), .o_running(o_running),
  .o_counter(o_counter));
`default_nettype wire

// *** bench/tmrev_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tmrev_top_tb;
  logic         i_clk_sys = 1'b0;
  logic         i_rst_b   = 1'b0;
  logic [11:0]  i_addr    = 12'h000;
  logic [31:0]  i_wdata   = 32'h0;
  logic         i_wr      = 1'b0;
  logic         i_rd      = 1'b0;
  logic [31:0]  o_rdata;
  logic [255:0] i_evchan;
  logic [255:0] o_evchan;
  logic         o_irq;
  logic         o_running;
  logic [31:0]  o_counter;
  logic [31:0]  rdv;
  int           num_errors = 0;
  int           samples_checked = 0;
  always #4 i_clk_sys = ~i_clk_sys;
  tmrev_top i_tmrev_top (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_evchan(i_evchan),
    .o_evchan(o_evchan), .o_irq(o_irq), .o_running(o_running), .o_counter(o_counter));
  tmrev_evnet i_tmrev_evnet (.i_clk(i_clk_sys), .i_pub(o_evchan), .o_chan(i_evchan));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    #1;
    rdv = o_rdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, 1'b1, a, 32'h0);
    check(rdv, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 12'h000, 32'h0);
  endtask
  task automatic fire(input logic [7:0] ch);
    idle(1);
    i_tmrev_evnet.fire(ch);
    idle(5);
  endtask
  task automatic rt(input logic [11:0] a);
    rdc(a, tmrev_pkg::RST_WORD);
    wr(a, 32'hFFFFFFFF);
    rdc(a, tmrev_pkg::SUB_MASK);
    wr(a, 32'h0);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 5; i++) rt(tmrev_pkg::OFF_SUB_START + 12'(4 * i));
    for (int i = 0; i < 6; i++) rt(tmrev_pkg::OFF_SUB_CAPT + 12'(4 * i));
    for (int i = 0; i < 6; i++) rt(tmrev_pkg::OFF_PUB + 12'(4 * i));
    wr(tmrev_pkg::OFF_EVENT_TASK_SHORTCUTS, 32'hFFFFFFFF);
    rdc(tmrev_pkg::OFF_EVENT_TASK_SHORTCUTS, 32'h00000FFF);
    wr(tmrev_pkg::OFF_EVENT_TASK_SHORTCUTS, 32'h0);
    rdc(12'hFFC, 32'h0);
  endtask
  task automatic t_irq();
    wr(tmrev_pkg::OFF_INTSET, 32'h5);
    rdc(tmrev_pkg::OFF_INTCLR, 32'h5);
    wr(tmrev_pkg::OFF_INTSET, 32'h0);
    rdc(tmrev_pkg::OFF_INTSET, 32'h5);
    wr(tmrev_pkg::OFF_INTCLR, 32'h1);
    wr(tmrev_pkg::OFF_INTCLR, 32'h0);
    rdc(tmrev_pkg::OFF_INTSET, 32'h4);
    wr(tmrev_pkg::OFF_INTCLR, 32'h3F);
    rdc(tmrev_pkg::OFF_INTSET, 32'h0);
  endtask
  task automatic t_capt();
    wr(tmrev_pkg::OFF_MODE, 32'h1);
    wr(tmrev_pkg::OFF_CLEAR, 32'h1);
    wr(tmrev_pkg::OFF_START, 32'h1);
    repeat (3) wr(tmrev_pkg::OFF_COUNT, 32'h1);
    idle(2);
    check(o_counter, 32'h3);
    for (int n = 0; n < 6; n++) begin
      wr(tmrev_pkg::OFF_CAPT + 12'(4 * n), 32'h1);
      rdc(tmrev_pkg::OFF_CCV + 12'(4 * n), 32'h3);
    end
  endtask
  task automatic t_clrcap();
    wr(tmrev_pkg::OFF_SUB_CAPT, 32'h80000007);
    wr(tmrev_pkg::OFF_SUB_CLEAR, 32'h80000007);
    fire(8'h07);
    rdc(tmrev_pkg::OFF_CCV, 32'h0);
    check(o_counter, 32'h0);
    wr(tmrev_pkg::OFF_SUB_CAPT, 32'h0);
  endtask
  task automatic t_startstop();
    wr(tmrev_pkg::OFF_STOP, 32'h1);
    wr(tmrev_pkg::OFF_SUB_START, 32'h8000000A);
    wr(tmrev_pkg::OFF_SUB_STOP, 32'h8000000A);
    fire(8'h0A);
    check({31'h0, o_running}, 32'h0);
    wr(tmrev_pkg::OFF_SUB_STOP, 32'h0000000A);
    fire(8'h0A);
    check({31'h0, o_running}, 32'h1);
    wr(tmrev_pkg::OFF_SUB_STOP, 32'h8000000B);
    fire(8'h0B);
    check({31'h0, o_running}, 32'h0);
  endtask
  task automatic t_cmp();
    wr(tmrev_pkg::OFF_CLEAR, 32'h1);
    wr(tmrev_pkg::OFF_START, 32'h1);
    repeat (2) wr(tmrev_pkg::OFF_COUNT, 32'h1);
    wr(tmrev_pkg::OFF_CAPT + 12'h4, 32'h1);
    wr(tmrev_pkg::OFF_CLEAR, 32'h1);
    wr(tmrev_pkg::OFF_INTSET, 32'h2);
    wr(tmrev_pkg::OFF_PUB + 12'h4, 32'h80000014);
    wr(tmrev_pkg::OFF_EVENT_TASK_SHORTCUTS, 32'h00000082);
    repeat (2) wr(tmrev_pkg::OFF_COUNT, 32'h1);
    idle(3);
    rdc(tmrev_pkg::OFF_EVT + 12'h4, 32'h1);
    check({31'h0, o_irq}, 32'h1);
    check(o_counter, 32'h0);
    check({31'h0, o_running}, 32'h0);
    check(i_tmrev_evnet.pub_cnt, 32'h1);
    check({24'h0, i_tmrev_evnet.pub_idx}, 32'h14);
    wr(tmrev_pkg::OFF_INTCLR, 32'h3F);
    idle(1);
    check({31'h0, o_irq}, 32'h0);
  endtask
  task automatic final_report();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    #1;
    t_regs();
    t_irq();
    t_capt();
    t_clrcap();
    t_startstop();
    t_cmp();
    final_report();
  end
  initial begin
    #40000;
    num_errors++;
    final_report();
  end
endmodule // tmrev_top_tb
`default_nettype wire

// *** verilog/tmrev_chsel.sv ***
`timescale 1ns/1ns
`default_nettype none
// Picks one interconnect channel pulse by index, gated by the enable
module tmrev_chsel (
  input  wire logic [255:0] i_chan,
  input  wire logic [31:0]  i_cfg,
  output logic              o_hit
);
  assign o_hit = i_cfg[tmrev_pkg::EN_BIT] & i_chan[i_cfg[7:0]];
endmodule // tmrev_chsel
`default_nettype wire

// *** verilog/tmrev_pkg.sv ***
// Function
// - Writing one to capture-trigger word n captures the counter into channel n
// - Start subscription holds channel index and enable; enabled channel pulse starts timer
// - Stop subscription holds channel index and enable; enabled channel pulse stops timer
// - Increment subscription triggers count task, effective only in counter mode
// - Clear subscription triggers the clear task, zeroing the counter
// - Shutdown subscription word is storage only, with no function
// - Six capture subscriptions trigger capture of channel n independently
// - Six event registers record a compare match of the counter
// - Six publication registers broadcast compare events on a chosen channel when enabled
// - Shortcut bit per channel makes compare trigger clear
// - Second shortcut bit per channel makes compare trigger stop
// - Writing one to irq set enables that interrupt; read returns enables
// - Writing one to irq clear disables that interrupt; read returns enables
// - Capture copies the present counter value into the channel register
// - Compare fires when counter increments and then equals the channel value
// - Stop wins over start in the same clock period
// - Clear wins over capture in the same period, capture receives zero
package tmrev_pkg;
  localparam int          NCH            = 6;
  localparam int          AW             = 12;
  localparam logic [11:0] OFF_START      = 12'h000;
  localparam logic [11:0] OFF_STOP       = 12'h004;
  localparam logic [11:0] OFF_COUNT      = 12'h008;
  localparam logic [11:0] OFF_CLEAR      = 12'h00C;
  localparam logic [11:0] OFF_CAPT       = 12'h040;
  localparam logic [11:0] OFF_SUB_START  = 12'h080;
  localparam logic [11:0] OFF_SUB_STOP   = 12'h084;
  localparam logic [11:0] OFF_SUB_COUNT  = 12'h088;
  localparam logic [11:0] OFF_SUB_CLEAR  = 12'h08C;
  localparam logic [11:0] OFF_SUB_SHDN   = 12'h090;
  localparam logic [11:0] OFF_SUB_CAPT   = 12'h0C0;
  localparam logic [11:0] OFF_EVT        = 12'h140;
  localparam logic [11:0] OFF_PUB        = 12'h1C0;
  localparam logic [11:0] OFF_EVENT_TASK_SHORTCUTS     = 12'h200;
  localparam logic [11:0] OFF_INTSET     = 12'h304;
  localparam logic [11:0] OFF_INTCLR     = 12'h308;
  localparam logic [11:0] OFF_MODE       = 12'h504;
  localparam logic [11:0] OFF_CCV        = 12'h540;
  localparam int          EN_BIT         = 31;
  localparam int          SC_STOP_LSB    = 6;
  localparam logic [31:0] RST_WORD       = 32'h00000000;
  localparam logic [31:0] SUB_MASK       = 32'h800000FF;
  localparam logic [11:0] EVENT_TASK_SHORTCUTS_MASK    = 12'hFFF;
endpackage

// *** verilog/tmrev_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tmrev_top (
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst_b,
  input  wire logic [11:0]   i_addr,
  input  wire logic [31:0]   i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [31:0]   o_rdata,
  input  wire logic [255:0]  i_evchan,
  output logic      [255:0]  o_evchan,
  output logic               o_irq,
  output logic               o_running,
  output logic      [31:0]   o_counter
);
  localparam int N = tmrev_pkg::NCH;

  function automatic logic [31:0] sub_fmt(input logic [31:0] w);
    sub_fmt = w & tmrev_pkg::SUB_MASK;
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction

  // Index of an arrayed register at base, or N when outside
  function automatic int arr_idx(input logic [11:0] a, input logic [11:0] base);
    int k;
    arr_idx = N;
    for (k = 0; k < N; k++) begin
      if (a == base + 12'(4 * k)) begin
        arr_idx = k;
      end
    end
  endfunction

  logic [31:0] sub_start_ff, sub_stop_ff, sub_count_ff, sub_clear_ff, sub_shdn_ff;
  logic [31:0] sub_capt_ff [N];
  logic [31:0] pub_ff      [N];
  logic [31:0] ccv_ff      [N];
  logic [N-1:0]  evt_ff, inten_ff, match_ff, evt_d_ff;
  logic [11:0]   event_task_shortcuts_ff;
  logic          mode_ff, running_ff, irq_ff;
  logic [31:0]   cnt_ff, rdata_ff;
  logic [255:0]  evchan_ff;
  logic [255:0]  evchan_s1_ff, evchan_s2_ff;

  logic [31:0] nxt_sub_start, nxt_sub_stop, nxt_sub_count, nxt_sub_clear, nxt_sub_shdn;
  logic [31:0] nxt_sub_capt [N];
  logic [31:0] nxt_pub      [N];
  logic [31:0] nxt_ccv      [N];
  logic [N-1:0]  nxt_evt, nxt_inten, match;
  logic [11:0]   nxt_event_task_shortcuts;
  logic          nxt_mode, nxt_running, nxt_irq;
  logic [31:0]   nxt_cnt, nxt_rdata;
  logic [255:0]  nxt_evchan;
  logic          h_start, h_stop, h_count, h_clear;
  logic [N-1:0]  h_capt;
  logic          t_start, t_stop, t_count, t_clear, incr;
  logic [N-1:0]  t_capt;
  logic [31:0]   cnt_inc;

  tmrev_chsel u_sel_start (.i_chan(evchan_s2_ff), .i_cfg(sub_start_ff), .o_hit(h_start));
  tmrev_chsel u_sel_stop  (.i_chan(evchan_s2_ff), .i_cfg(sub_stop_ff),  .o_hit(h_stop));
  tmrev_chsel u_sel_count (.i_chan(evchan_s2_ff), .i_cfg(sub_count_ff), .o_hit(h_count));
  tmrev_chsel u_sel_clear (.i_chan(evchan_s2_ff), .i_cfg(sub_clear_ff), .o_hit(h_clear));

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cap
      tmrev_chsel u_sel_capt (.i_chan(evchan_s2_ff), .i_cfg(sub_capt_ff[g]), .o_hit(h_capt[g]));
    end
  endgenerate

  // Task decode, counter and capture
  always_comb begin
    int k;
    int wi;
    k = 0;
    wi = N;
    t_start = h_start | (i_wr && hit(i_addr, tmrev_pkg::OFF_START) && i_wdata[0]);
    t_stop  = h_stop  | (i_wr && hit(i_addr, tmrev_pkg::OFF_STOP)  && i_wdata[0]);
    t_count = h_count | (i_wr && hit(i_addr, tmrev_pkg::OFF_COUNT) && i_wdata[0]);
    t_clear = h_clear | (i_wr && hit(i_addr, tmrev_pkg::OFF_CLEAR) && i_wdata[0]);
    wi = arr_idx(i_addr, tmrev_pkg::OFF_CAPT);
    for (k = 0; k < N; k++) begin
      t_capt[k] = h_capt[k] | (i_wr && wi == k && i_wdata[0]);
    end
    // Shortcuts act on the events registered last cycle
    // Registered matches break the loop from clear back into the compare
    t_clear = t_clear | (|(match_ff & event_task_shortcuts_ff[5:0]));
    t_stop  = t_stop  | (|(match_ff & event_task_shortcuts_ff[11:6]));
    nxt_running = running_ff;
    if (t_start) begin
      nxt_running = 1'b1;
    end
    if (t_stop) begin
      nxt_running = 1'b0;
    end
    incr    = running_ff && (mode_ff ? t_count : 1'b1);
    cnt_inc = cnt_ff + 32'h00000001;
    nxt_cnt = cnt_ff;
    if (t_clear) begin
      nxt_cnt = 32'h00000000;
    end else if (incr) begin
      nxt_cnt = cnt_inc;
    end
    for (k = 0; k < N; k++) begin
      nxt_ccv[k] = ccv_ff[k];
      if (t_capt[k]) begin
        nxt_ccv[k] = t_clear ? 32'h00000000 : cnt_ff;
      end
    end
  end

  // Register file writes, event flags, publication and read data
  always_comb begin
    int k;
    int ie, ip, is, ic;
    k = 0;
    nxt_sub_start = sub_start_ff;
    nxt_sub_stop  = sub_stop_ff;
    nxt_sub_count = sub_count_ff;
    nxt_sub_clear = sub_clear_ff;
    nxt_sub_shdn  = sub_shdn_ff;
    nxt_event_task_shortcuts    = event_task_shortcuts_ff;
    nxt_inten     = inten_ff;
    nxt_mode      = mode_ff;
    nxt_rdata     = tmrev_pkg::RST_WORD;
    nxt_evchan    = '0;
    ie = arr_idx(i_addr, tmrev_pkg::OFF_EVT);
    ip = arr_idx(i_addr, tmrev_pkg::OFF_PUB);
    is = arr_idx(i_addr, tmrev_pkg::OFF_SUB_CAPT);
    ic = arr_idx(i_addr, tmrev_pkg::OFF_CCV);
    for (k = 0; k < N; k++) begin
      nxt_sub_capt[k] = sub_capt_ff[k];
      nxt_pub[k]      = pub_ff[k];
      // Compare on the incremented value; set beats a software clear
      match[k] = incr && !t_clear && (cnt_inc == ccv_ff[k]);
      nxt_evt[k] = evt_ff[k];
      if (i_wr && ie == k) begin
        nxt_evt[k] = i_wdata[0];
      end
      if (match[k]) begin
        nxt_evt[k] = 1'b1;
      end
      if (evt_ff[k] && !evt_d_ff[k] && pub_ff[k][tmrev_pkg::EN_BIT]) begin
        nxt_evchan[pub_ff[k][7:0]] = 1'b1;
      end
    end
    if (i_wr) begin
      if (hit(i_addr, tmrev_pkg::OFF_SUB_START)) begin
        nxt_sub_start = sub_fmt(i_wdata);
      end else if (hit(i_addr, tmrev_pkg::OFF_SUB_STOP)) begin
        nxt_sub_stop = sub_fmt(i_wdata);
      end else if (hit(i_addr, tmrev_pkg::OFF_SUB_COUNT)) begin
        nxt_sub_count = sub_fmt(i_wdata);
      end else if (hit(i_addr, tmrev_pkg::OFF_SUB_CLEAR)) begin
        nxt_sub_clear = sub_fmt(i_wdata);
      end else if (hit(i_addr, tmrev_pkg::OFF_SUB_SHDN)) begin
        nxt_sub_shdn = sub_fmt(i_wdata);
      end else if (is < N) begin
        nxt_sub_capt[is] = sub_fmt(i_wdata);
      end else if (ip < N) begin
        nxt_pub[ip] = sub_fmt(i_wdata);
      end else if (hit(i_addr, tmrev_pkg::OFF_EVENT_TASK_SHORTCUTS)) begin
        nxt_event_task_shortcuts = i_wdata[11:0] & tmrev_pkg::EVENT_TASK_SHORTCUTS_MASK;
      end else if (hit(i_addr, tmrev_pkg::OFF_INTSET)) begin
        nxt_inten = inten_ff | i_wdata[N-1:0];
      end else if (hit(i_addr, tmrev_pkg::OFF_INTCLR)) begin
        nxt_inten = inten_ff & ~i_wdata[N-1:0];
      end else if (hit(i_addr, tmrev_pkg::OFF_MODE)) begin
        nxt_mode = i_wdata[0];
      end
    end
    if (i_rd) begin
      if (hit(i_addr, tmrev_pkg::OFF_SUB_START)) begin
        nxt_rdata = sub_start_ff;
      end else if (hit(i_addr, tmrev_pkg::OFF_SUB_STOP)) begin
        nxt_rdata = sub_stop_ff;
      end else if (hit(i_addr, tmrev_pkg::OFF_SUB_COUNT)) begin
        nxt_rdata = sub_count_ff;
      end else if (hit(i_addr, tmrev_pkg::OFF_SUB_CLEAR)) begin
        nxt_rdata = sub_clear_ff;
      end else if (hit(i_addr, tmrev_pkg::OFF_SUB_SHDN)) begin
        nxt_rdata = sub_shdn_ff;
      end else if (is < N) begin
        nxt_rdata = sub_capt_ff[is];
      end else if (ie < N) begin
        nxt_rdata = {31'h00000000, evt_ff[ie]};
      end else if (ip < N) begin
        nxt_rdata = pub_ff[ip];
      end else if (ic < N) begin
        nxt_rdata = ccv_ff[ic];
      end else if (hit(i_addr, tmrev_pkg::OFF_EVENT_TASK_SHORTCUTS)) begin
        nxt_rdata = {20'h00000, event_task_shortcuts_ff};
      end else if (hit(i_addr, tmrev_pkg::OFF_INTSET) || hit(i_addr, tmrev_pkg::OFF_INTCLR)) begin
        nxt_rdata = {26'h0000000, inten_ff};
      end else if (hit(i_addr, tmrev_pkg::OFF_MODE)) begin
        nxt_rdata = {31'h00000000, mode_ff};
      end
    end
    nxt_irq = |(nxt_evt & nxt_inten);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sub_start_ff <= tmrev_pkg::RST_WORD;
      sub_stop_ff  <= tmrev_pkg::RST_WORD;
      sub_count_ff <= tmrev_pkg::RST_WORD;
      sub_clear_ff <= tmrev_pkg::RST_WORD;
      sub_shdn_ff  <= tmrev_pkg::RST_WORD;
      for (int k = 0; k < N; k++) begin
        sub_capt_ff[k] <= tmrev_pkg::RST_WORD;
        pub_ff[k]      <= tmrev_pkg::RST_WORD;
        ccv_ff[k]      <= tmrev_pkg::RST_WORD;
      end
      evt_ff       <= '0;
      match_ff     <= '0;
      evt_d_ff     <= '0;
      inten_ff     <= '0;
      event_task_shortcuts_ff    <= 12'h000;
      mode_ff      <= 1'b0;
      running_ff   <= 1'b0;
      irq_ff       <= 1'b0;
      cnt_ff       <= tmrev_pkg::RST_WORD;
      rdata_ff     <= tmrev_pkg::RST_WORD;
      evchan_ff    <= '0;
      evchan_s1_ff <= '0;
      evchan_s2_ff <= '0;
    end else begin
      sub_start_ff <= nxt_sub_start;
      sub_stop_ff  <= nxt_sub_stop;
      sub_count_ff <= nxt_sub_count;
      sub_clear_ff <= nxt_sub_clear;
      sub_shdn_ff  <= nxt_sub_shdn;
      for (int k = 0; k < N; k++) begin
        sub_capt_ff[k] <= nxt_sub_capt[k];
        pub_ff[k]      <= nxt_pub[k];
        ccv_ff[k]      <= nxt_ccv[k];
      end
      evt_ff       <= nxt_evt;
      match_ff     <= match;
      evt_d_ff     <= evt_ff;
      inten_ff     <= nxt_inten;
      event_task_shortcuts_ff    <= nxt_event_task_shortcuts;
      mode_ff      <= nxt_mode;
      running_ff   <= nxt_running;
      irq_ff       <= nxt_irq;
      cnt_ff       <= nxt_cnt;
      rdata_ff     <= nxt_rdata;
      evchan_ff    <= nxt_evchan;
      evchan_s1_ff <= i_evchan;
      evchan_s2_ff <= evchan_s1_ff;
    end
  end

  assign o_rdata   = rdata_ff;
  assign o_evchan  = evchan_ff;
  assign o_irq     = irq_ff;
  assign o_running = running_ff;
  assign o_counter = cnt_ff;
endmodule // tmrev_top
`default_nettype wire
